// ### emwd_cpu.sv
`timescale 1ns/1ns
`include "emwd_defines.svh"
module emwd_cpu (
  // link side
  emwd_bus_if.cpu bus,
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // user request
  input wire logic req,
  input wire logic req_write,
  input wire logic [15:0] req_addr,
  input wire logic [7:0] req_wdata,
  output logic busy,
  output logic done,
  output logic internal_hit,
  output logic [7:0] rdata
);
  // ************************************************************
  // sequencer: phases after idle advance on rising processor-clock edges, wait, data and end may span several
  // ************************************************************
  emwd_pkg::emwd_phase_e ph_reg, ph_next;
  logic [2:0] div_reg, div_next;
  logic [2:0] cnt_reg, cnt_next;
  logic [1:0] w1_reg, w2_reg;
  logic ck_reg, ck_next, ale_reg, ale_next, stb_reg, stb_next, rw_reg, rw_next;
  logic [7:0] lo_reg, lo_next, ad_reg, ad_next, rd_reg, rd_next;
  logic adoe_reg, adoe_next, busy_reg, busy_next, done_reg, done_next, ih_reg, ih_next;
  logic wr_reg, wr_next;
  logic [15:0] a_reg, a_next;
  logic [7:0] wd_reg, wd_next;
  logic tick, is_int_ram, is_int_rom;
  // divider terminal count; the processor clock toggles every HALF+1 mclk cycles
  localparam logic [2:0] HALF = 3'((`EMWD_CYCLE_CLKS) / 2);
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      w1_reg <= 2'b00;
      w2_reg <= 2'b00;
    end else begin
      w1_reg <= {bus.mem_wait, 1'b0};
      w2_reg <= w1_reg;
    end
  end
  assign tick = (div_reg == HALF) & ~ck_reg; // a rising processor-clock edge
  // internal rom assumed enabled
  assign is_int_ram = (req_addr >= `EMWD_INT_RAM_LO) && (req_addr <= `EMWD_INT_RAM_HI);
  assign is_int_rom = (req_addr >= `EMWD_INT_ROM_LO) && (req_addr <= `EMWD_INT_ROM_HI);
  always_comb begin
    ph_next = ph_reg;
    cnt_next = cnt_reg;
    div_next = (div_reg == HALF) ? 3'h0 : div_reg + 3'h1;
    ck_next = (div_reg == HALF) ? ~ck_reg : ck_reg;
    ale_next = ale_reg;
    stb_next = stb_reg;
    rw_next = rw_reg;
    lo_next = lo_reg;
    ad_next = ad_reg;
    adoe_next = adoe_reg;
    rd_next = rd_reg;
    busy_next = busy_reg;
    done_next = 1'b0;
    ih_next = ih_reg;
    wr_next = wr_reg;
    a_next = a_reg;
    wd_next = wd_reg;
    case (ph_reg)
      emwd_pkg::EMWD_IDLE: begin
        if (req && !busy_reg) begin
          busy_next = 1'b1;
          a_next = req_addr;
          wd_next = req_wdata;
          wr_next = req_write;
          if (is_int_ram || is_int_rom) begin
            ih_next = 1'b1;
            cnt_next = is_int_ram ? 3'h1 : 3'(`EMWD_ROM_CYCLES);
            ph_next = emwd_pkg::EMWD_END;
          end else begin
            ih_next = 1'b0;
            cnt_next = 3'(`EMWD_EXT_CYCLES - 1);
            ph_next = emwd_pkg::EMWD_ADDR;
          end
        end
      end
      emwd_pkg::EMWD_ADDR: if (tick) begin
        ale_next = 1'b1;
        ad_next = a_reg[15:8];
        lo_next = a_reg[7:0];
        adoe_next = 1'b1;
        rw_next = ~wr_reg;
        ph_next = emwd_pkg::EMWD_STROBE;
      end
      emwd_pkg::EMWD_STROBE: if (tick) begin
        ale_next = 1'b0;
        stb_next = 1'b0;
        adoe_next = wr_reg;
        ad_next = wd_reg;
        cnt_next = cnt_reg - 3'h1;
        ph_next = emwd_pkg::EMWD_WAIT;
      end
      emwd_pkg::EMWD_WAIT: if (tick) begin
        if (!w2_reg[1]) begin
          cnt_next = cnt_reg - 3'h1;
          ph_next = emwd_pkg::EMWD_DATA;
        end
      end
      emwd_pkg::EMWD_DATA: if (tick) begin
        if (cnt_reg == 3'h1) begin
          rd_next = bus.upper_addr_data_pins;
          stb_next = 1'b1;
          adoe_next = 1'b0;
          ph_next = emwd_pkg::EMWD_END;
        end else begin
          cnt_next = cnt_reg - 3'h1;
        end
      end
      emwd_pkg::EMWD_END: if (tick) begin
        if (cnt_reg <= 3'h1) begin
          busy_next = 1'b0;
          done_next = 1'b1;
          rw_next = 1'b1;
          ph_next = emwd_pkg::EMWD_IDLE;
        end else begin
          cnt_next = cnt_reg - 3'h1;
        end
      end
      default: ph_next = emwd_pkg::EMWD_IDLE;
    endcase
  end
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      ph_reg <= emwd_pkg::EMWD_IDLE;
      cnt_reg <= 3'h0;
      div_reg <= 3'h0;
      ck_reg <= 1'b0;
      ale_reg <= 1'b0;
      stb_reg <= 1'b1;
      rw_reg <= 1'b1;
      lo_reg <= `EMWD_BYTE_RESET;
      ad_reg <= `EMWD_BYTE_RESET;
      adoe_reg <= 1'b0;
      rd_reg <= `EMWD_BYTE_RESET;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
      ih_reg <= 1'b0;
      wr_reg <= 1'b0;
      a_reg <= 16'h0000;
      wd_reg <= `EMWD_BYTE_RESET;
    end else begin
      ph_reg <= ph_next;
      cnt_reg <= cnt_next;
      div_reg <= div_next;
      ck_reg <= ck_next;
      ale_reg <= ale_next;
      stb_reg <= stb_next;
      rw_reg <= rw_next;
      lo_reg <= lo_next;
      ad_reg <= ad_next;
      adoe_reg <= adoe_next;
      rd_reg <= rd_next;
      busy_reg <= busy_next;
      done_reg <= done_next;
      ih_reg <= ih_next;
      wr_reg <= wr_next;
      a_reg <= a_next;
      wd_reg <= wd_next;
    end
  end
  assign bus.cpu_clk_out = ck_reg;
  assign bus.addr_latch = ale_reg;
  assign bus.mem_strobe_low = stb_reg;
  assign bus.read_write_dir = rw_reg;
  assign bus.lower_addr_pins = lo_reg;
  assign bus.upper_addr_data_pins_cpu_o = ad_reg;
  assign bus.upper_addr_data_pins_cpu_oe = adoe_reg;
  assign busy = busy_reg;
  assign done = done_reg;
  assign internal_hit = ih_reg;
  assign rdata = rd_reg;
endmodule

// ### emwd_defines.svh
`ifndef EMWD_DEFINES_SVH
`define EMWD_DEFINES_SVH
// ************************************************************
// memory map
// ************************************************************
`define EMWD_INT_RAM_LO 16'h8000
`define EMWD_INT_RAM_HI 16'h87FF
`define EMWD_EXT_LO 16'h8800
`define EMWD_INT_ROM_LO 16'h7000
`define EMWD_INT_ROM_HI 16'h7FFF
// ************************************************************
// timing
// ************************************************************
`define EMWD_CYCLE_NS 50
`define EMWD_CLK_NS 10
`define EMWD_CYCLE_CLKS ((`EMWD_CYCLE_NS + `EMWD_CLK_NS - 1) / `EMWD_CLK_NS)
`define EMWD_ROM_CYCLES 3
`define EMWD_EXT_CYCLES 5
// ************************************************************
// field positions and widths
// ************************************************************
`define EMWD_WAIT_SEL_W 3
`define EMWD_TAPS 8
`define EMWD_ADDR_SIX_POS 6
`define EMWD_ADDR_TOP_POS 7
`define EMWD_TAPS_RESET 8'h00
`define EMWD_BYTE_RESET 8'h00
`endif

// ### emwd_pkg.sv
package emwd_pkg;
  typedef logic [7:0] emwd_byte_t;
  typedef logic [2:0] emwd_sel_t;
  typedef enum logic [2:0] {
    EMWD_IDLE,
    EMWD_ADDR,
    EMWD_STROBE,
    EMWD_WAIT,
    EMWD_DATA,
    EMWD_END
  } emwd_phase_e;
endpackage

// ### emwd_bus_if.sv
`timescale 1ns/1ns
interface emwd_bus_if;
  logic cpu_clk_out;
  logic addr_latch;
  logic mem_strobe_low;
  logic read_write_dir;
  logic mem_wait;
  logic [7:0] lower_addr_pins;
  logic [7:0] upper_addr_data_pins_cpu_o;
  logic upper_addr_data_pins_cpu_oe;
  logic [7:0] upper_addr_data_pins_glue_o;
  logic upper_addr_data_pins_glue_oe;
  logic [7:0] upper_addr_data_pins;
  assign upper_addr_data_pins = upper_addr_data_pins_cpu_oe ? upper_addr_data_pins_cpu_o :
                                upper_addr_data_pins_glue_oe ? upper_addr_data_pins_glue_o : 8'h00;
  modport glue (
    input cpu_clk_out, addr_latch, mem_strobe_low, read_write_dir, lower_addr_pins, upper_addr_data_pins,
    output mem_wait, upper_addr_data_pins_glue_o, upper_addr_data_pins_glue_oe
  );
  modport cpu (
    output cpu_clk_out, addr_latch, mem_strobe_low, read_write_dir, lower_addr_pins,
    output upper_addr_data_pins_cpu_o, upper_addr_data_pins_cpu_oe,
    input mem_wait, upper_addr_data_pins
  );
endinterface

// ### emwd_glue.sv
`timescale 1ns/1ns
`include "emwd_defines.svh"
// Overview of operation
// - cpu on-chip ram at 8000 to 87FF
// - 8800 upward goes to external cycles
// - on-chip rom 7000-7FFF, always enabled in the cpu model
// - ram one cycle, rom three cycles
// - data byte shares upper address pins
// - external access five cycles without waits
// - cpu stretches access while wait high
// - wait sampled low lets access finish
// - three select bits pick one tap
// - shift register shifts ones during strobe
// - wait high until selected tap is one
// - zero to seven periods inserted
// - one wait count for all addresses
// - upper address byte latched, always enabled
// - lower address byte wired straight through
// - buffer direction from rw, drives during strobe
// - jumper picks bit six or rw as msb
// - bit seven low selects first device
// - bit seven high selects second device
// - two 32k byte devices, ram or eprom each
module emwd_glue (
  // processor side
  emwd_bus_if.glue bus,
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // static straps
  input wire logic [2:0] wait_sel,
  input wire logic ram_rom_jumper_a,
  input wire logic ram_rom_jumper_b,
  // memory devices
  output logic [14:0] mem_addr_a,
  output logic [14:0] mem_addr_b,
  output logic mem_sel_a_low,
  output logic mem_sel_b_low,
  output logic mem_write_low,
  output logic [7:0] mem_data_o,
  output logic mem_data_oe,
  input wire logic [7:0] mem_data_i
);
  // ************************************************************
  // pin synchronisers
  // ************************************************************
  logic [5:0] s1_reg, s2_reg;
  logic [7:0] d1_reg, d2_reg, l1_reg, l2_reg, m1_reg, m2_reg;
  logic ck_prev_reg, ck_prev_next;
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      s1_reg <= 6'h3f;
      s2_reg <= 6'h3f;
      d1_reg <= `EMWD_BYTE_RESET;
      d2_reg <= `EMWD_BYTE_RESET;
      l1_reg <= `EMWD_BYTE_RESET;
      l2_reg <= `EMWD_BYTE_RESET;
      m1_reg <= `EMWD_BYTE_RESET;
      m2_reg <= `EMWD_BYTE_RESET;
    end else begin
      s1_reg <= {bus.cpu_clk_out, bus.addr_latch, bus.mem_strobe_low, bus.read_write_dir, 2'b00};
      s2_reg <= s1_reg;
      d1_reg <= bus.upper_addr_data_pins;
      d2_reg <= d1_reg;
      l1_reg <= bus.lower_addr_pins;
      l2_reg <= l1_reg;
      m1_reg <= mem_data_i;
      m2_reg <= m1_reg;
    end
  end
  logic ck_s, ale_s, strobe_low_s, rw_s;
  assign ck_s = s2_reg[5];
  assign ale_s = s2_reg[4];
  assign strobe_low_s = s2_reg[3];
  assign rw_s = s2_reg[2];
  // ************************************************************
  // wait generator and outputs
  // ************************************************************
  logic [7:0] taps_reg, taps_next;
  logic wait_reg, wait_next;
  logic [7:0] upper_reg, upper_next;
  logic [14:0] addr_a_reg, addr_a_next, addr_b_reg, addr_b_next;
  logic sel_a_reg, sel_a_next, sel_b_reg, sel_b_next, wr_reg, wr_next;
  logic [7:0] mo_reg, mo_next, co_reg, co_next;
  logic moe_reg, moe_next, coe_reg, coe_next;
  logic rising;
  // tap 0 is a constant one so a zero setting adds nothing
  logic [8:0] tap_vec;
  logic msb_a, msb_b;
  assign rising = ck_s & ~ck_prev_reg;
  always_comb begin
    ck_prev_next = ck_s;
    taps_next = taps_reg;
    if (strobe_low_s) begin
      taps_next = `EMWD_TAPS_RESET;
    end else if (rising) begin
      taps_next = {taps_reg[6:0], 1'b1};
    end
    // sum of weights picks the tap
    tap_vec = {taps_reg, 1'b1};
    wait_next = ~strobe_low_s & ~tap_vec[wait_sel];
    upper_next = ale_s ? d2_reg : upper_reg;
    // latched address bit, the pins carry data once the strobe is low
    msb_a = ram_rom_jumper_a ? upper_reg[`EMWD_ADDR_SIX_POS] : rw_s;
    msb_b = ram_rom_jumper_b ? upper_reg[`EMWD_ADDR_SIX_POS] : rw_s;
    addr_a_next = {msb_a, upper_reg[5:0], l2_reg};
    addr_b_next = {msb_b, upper_reg[5:0], l2_reg};
    sel_a_next = strobe_low_s | upper_reg[`EMWD_ADDR_TOP_POS];
    sel_b_next = strobe_low_s | ~upper_reg[`EMWD_ADDR_TOP_POS];
    wr_next = strobe_low_s | rw_s;
    // buffer: write toward memory, read toward cpu
    moe_next = ~strobe_low_s & ~rw_s;
    mo_next = d2_reg;
    coe_next = ~strobe_low_s & rw_s;
    co_next = m2_reg;
  end
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      ck_prev_reg <= 1'b0;
      taps_reg <= `EMWD_TAPS_RESET;
      wait_reg <= 1'b0;
      upper_reg <= `EMWD_BYTE_RESET;
      addr_a_reg <= 15'h0000;
      addr_b_reg <= 15'h0000;
      sel_a_reg <= 1'b1;
      sel_b_reg <= 1'b1;
      wr_reg <= 1'b1;
      mo_reg <= `EMWD_BYTE_RESET;
      moe_reg <= 1'b0;
      co_reg <= `EMWD_BYTE_RESET;
      coe_reg <= 1'b0;
    end else begin
      ck_prev_reg <= ck_prev_next;
      taps_reg <= taps_next;
      wait_reg <= wait_next;
      upper_reg <= upper_next;
      addr_a_reg <= addr_a_next;
      addr_b_reg <= addr_b_next;
      sel_a_reg <= sel_a_next;
      sel_b_reg <= sel_b_next;
      wr_reg <= wr_next;
      mo_reg <= mo_next;
      moe_reg <= moe_next;
      co_reg <= co_next;
      coe_reg <= coe_next;
    end
  end
  assign bus.mem_wait = wait_reg;
  assign bus.upper_addr_data_pins_glue_o = co_reg;
  assign bus.upper_addr_data_pins_glue_oe = coe_reg;
  assign mem_addr_a = addr_a_reg;
  assign mem_addr_b = addr_b_reg;
  assign mem_sel_a_low = sel_a_reg;
  assign mem_sel_b_low = sel_b_reg;
  assign mem_write_low = wr_reg;
  assign mem_data_o = mo_reg;
  assign mem_data_oe = moe_reg;
endmodule

// ### emwd_bus_props.sv
`timescale 1ns/1ns
module emwd_bus_props (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // shared bus
  input wire logic cpu_clk_out,
  input wire logic addr_latch,
  input wire logic mem_strobe_low,
  input wire logic read_write_dir,
  input wire logic mem_wait,
  input wire logic upper_addr_data_pins_cpu_oe,
  input wire logic upper_addr_data_pins_glue_oe,
  // straps
  input wire logic [2:0] wait_sel
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  // ************************************************************
  // wait length helper
  // ************************************************************
  logic [3:0] rise_cnt_reg, rise_cnt_next;
  logic clk_d_reg;
  // saturates so a stuck wait cannot wrap back into range
  always_comb begin
    rise_cnt_next = rise_cnt_reg;
    if (!mem_wait) rise_cnt_next = 4'h0;
    else if (cpu_clk_out && !clk_d_reg && rise_cnt_reg != 4'hf) rise_cnt_next = rise_cnt_reg + 4'h1;
  end
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      rise_cnt_reg <= 4'h0;
      clk_d_reg <= 1'b0;
    end else begin
      rise_cnt_reg <= rise_cnt_next;
      clk_d_reg <= cpu_clk_out;
    end
  end
  // ************************************************************
  // properties
  // ************************************************************
  a_wait_tap_zero: assert property (wait_sel == 3'h0 |-> !mem_wait)
    else $error("wait raised with tap zero");
  a_wait_idle_low: assert property (mem_strobe_low [*4] |=> !mem_wait)
    else $error("wait high while strobe inactive");
  a_wait_from_strobe: assert property ($rose(mem_wait) |-> !mem_strobe_low)
    else $error("wait rose without strobe");
  a_wait_count_bound: assert property (mem_wait |-> rise_cnt_reg <= {1'b0, wait_sel} + 4'h2)
    else $error("wait longer than selected tap");
  a_wait_releases: assert property ($rose(mem_wait) |-> ##[1:60] !mem_wait)
    else $error("wait never released");
  a_no_contention: assert property (!(upper_addr_data_pins_cpu_oe && upper_addr_data_pins_glue_oe))
    else $error("both ends drive shared pins");
  a_glue_read_only: assert property ($rose(upper_addr_data_pins_glue_oe) |-> read_write_dir && !mem_strobe_low)
    else $error("glue drove pins outside read strobe");
  a_glue_idle_off: assert property (mem_strobe_low [*4] |=> !upper_addr_data_pins_glue_oe)
    else $error("glue drives while strobe inactive");
  a_cpu_write_data: assert property (upper_addr_data_pins_cpu_oe && !mem_strobe_low |-> !read_write_dir)
    else $error("cpu drove data during read strobe");
  a_latch_closed: assert property (!mem_strobe_low |-> !addr_latch)
    else $error("address latch open during strobe");
  a_strobe_ends: assert property ($fell(mem_strobe_low) |-> ##[1:400] mem_strobe_low)
    else $error("strobe never released");
  c_wait_seen: cover property ($fell(mem_wait));
endmodule

// ### ext_memory_wait_decode_tb.sv
`timescale 1ns/1ns
module ext_memory_wait_decode_tb;
  // ************************************************************
  // signals
  // ************************************************************
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic [2:0] wait_sel = 3'h0;
  logic jmp_a = 1'b1, jmp_b = 1'b1, cur_w = 1'b0;
  logic [14:0] mem_addr_a, mem_addr_b;
  logic mem_sel_a_low, mem_sel_b_low, mem_write_low, mem_data_oe, busy, done, internal_hit;
  logic [7:0] mem_data_o, mem_data_i, rdata, d, tick = 8'h00, req_wdata = 8'h00;
  logic req = 1'b0, req_write = 1'b0;
  logic [15:0] req_addr = 16'h0000, cur = 16'h0000, a;
  logic [7:0] dev [2][32768];
  logic [7:0] ref_mem [int];
  logic [15:0] int_list [4] = '{16'h8000, 16'h87ff, 16'h7000, 16'h7fff};
  int mismatches = 0, num_checks = 0, seed = 32'h75e7c163, falls = 0, len = 0, len0 = 0, slow = 0;
  emwd_bus_if bus ();
  initial begin
    forever #5 mclk = ~mclk;
  end
  emwd_cpu u_emwd_cpu (.bus(bus), .mclk(mclk), .reset(reset), .req(req), .req_write(req_write),
    .req_addr(req_addr), .req_wdata(req_wdata), .busy(busy), .done(done), .internal_hit(internal_hit), .rdata(rdata));
  emwd_glue u_emwd_glue (.bus(bus), .mclk(mclk), .reset(reset), .wait_sel(wait_sel), .ram_rom_jumper_a(jmp_a),
    .ram_rom_jumper_b(jmp_b), .mem_addr_a(mem_addr_a), .mem_addr_b(mem_addr_b), .mem_sel_a_low(mem_sel_a_low),
    .mem_sel_b_low(mem_sel_b_low), .mem_write_low(mem_write_low), .mem_data_o(mem_data_o),
    .mem_data_oe(mem_data_oe), .mem_data_i(mem_data_i));
  emwd_bus_props u_emwd_bus_props (.mclk(mclk), .reset(reset), .cpu_clk_out(bus.cpu_clk_out),
    .addr_latch(bus.addr_latch), .mem_strobe_low(bus.mem_strobe_low), .read_write_dir(bus.read_write_dir),
    .mem_wait(bus.mem_wait), .upper_addr_data_pins_cpu_oe(bus.upper_addr_data_pins_cpu_oe),
    .upper_addr_data_pins_glue_oe(bus.upper_addr_data_pins_glue_oe), .wait_sel(wait_sel));
  // ************************************************************
  // reference model
  // ************************************************************
  function automatic logic [7:0] pat(input int k);
    return k[7:0] ^ k[15:8];
  endfunction
  function automatic logic [14:0] exp_dev(input logic [15:0] ad, input logic w);
    logic j;
    j = ad[15] ? jmp_b : jmp_a;
    return {j ? ad[14] : !w, ad[13:0]};
  endfunction
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // ************************************************************
  // memory devices
  // ************************************************************
  // deselected devices return a moving pattern, never the last byte
  always_comb begin
    if (!mem_sel_a_low) mem_data_i = dev[0][mem_addr_a];
    else if (!mem_sel_b_low) mem_data_i = dev[1][mem_addr_b];
    else mem_data_i = tick;
  end
  always @(negedge bus.mem_strobe_low) if (!reset) falls++;
  always @(posedge mclk) begin
    tick <= tick + 8'h5b;
    // strobe length is phase-free, unlike request-to-done
    if (!reset && bus.mem_strobe_low === 1'b0) slow++;
    if (!reset && mem_sel_a_low === 1'b0) begin
      check("addr_a", 16'(mem_addr_a), 16'(exp_dev(cur, cur_w)));
      check("half_a", 16'(cur[15]), 16'h0000);
    end
    if (!reset && mem_sel_b_low === 1'b0) begin
      check("addr_b", 16'(mem_addr_b), 16'(exp_dev(cur, cur_w)));
      check("half_b", 16'(cur[15]), 16'h0001);
    end
    if (!reset && mem_write_low === 1'b0) begin
      check("data_oe", 16'(mem_data_oe), 16'h0001);
      if (!mem_sel_a_low) dev[0][mem_addr_a] <= mem_data_o;
      if (!mem_sel_b_low) dev[1][mem_addr_b] <= mem_data_o;
    end
  end
  // ************************************************************
  // one access, request held for one mclk cycle
  // ************************************************************
  task automatic acc(input logic w, input logic [15:0] ad, input logic [7:0] dt);
    int n;
    int k;
    k = int'({ad[15], exp_dev(ad, w)});
    cur = ad;
    cur_w = w;
    slow = 0;
    req = 1'b1;
    req_write = w;
    req_addr = ad;
    req_wdata = dt;
    @(posedge mclk);
    #1;
    req = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 500) begin
      @(posedge mclk);
      #1;
      n++;
    end
    if (n >= 500) begin
      mismatches++;
      close_out();
    end else begin
      len = slow;
      if (w) ref_mem[k] = dt;
      else if (internal_hit === 1'b0) check("rdata", 16'(rdata), 16'(ref_mem.exists(k) ? ref_mem[k] : pat(k)));
    end
  endtask
  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    for (int i = 0; i < 65536; i++) dev[i[15]][i[14:0]] = pat(i);
    repeat (6) @(posedge mclk);
    #1;
    check("reset_state", 16'({bus.mem_strobe_low, mem_sel_a_low, mem_sel_b_low, bus.mem_wait,
      bus.upper_addr_data_pins_glue_oe, bus.upper_addr_data_pins_cpu_oe, mem_data_oe, busy}), 16'h00e0);
    reset = 1'b0;
    // every tap, alternating halves; read right after write
    for (int s = 0; s < 8; s++) begin
      wait_sel = 3'(s);
      // bit 12 kept low so no pick lands in the internal rom range
      a = {s[0], s[1], 2'b10, 12'($random(seed))};
      d = 8'($random(seed));
      acc(1'b1, a, d);
      acc(1'b0, a, 8'h00);
      if (s == 0) len0 = len;
      check("wait_len", 16'(len - len0), 16'(6 * s));
    end
    falls = 0;
    foreach (int_list[i]) begin
      acc(1'b0, int_list[i], 8'h00);
      check("internal_hit", 16'(internal_hit), 16'h0001);
    end
    check("no_strobe", 16'(falls), 16'h0000);
    acc(1'b1, 16'h8800, 8'ha5);
    check("ext_hit", 16'(internal_hit), 16'h0000);
    check("one_strobe", 16'(falls), 16'h0001);
    acc(1'b0, 16'h8800, 8'h00);
    acc(1'b0, 16'h6fff, 8'h00);
    // eprom fit: rw becomes the top device address bit
    jmp_a = 1'b0;
    jmp_b = 1'b0;
    acc(1'b1, 16'h2345, 8'h3c);
    acc(1'b0, 16'h2345, 8'h00);
    acc(1'b0, 16'hb456, 8'h00);
    close_out();
  end
endmodule
